/* File: dv/rsm_ext_model.sv */
`default_nettype none
// ==========================================================
// External reset circuit and system clock source.
module rsm_ext_model (
   input wire logic clk,
   input wire logic pin_req,
   input wire logic stall,
   output logic rst_pin_n,
   output logic mon_clk
);
   timeunit 1ns;
   timeprecision 1ns;
   assign rst_pin_n = !pin_req;
   initial mon_clk = 1'b0;
   always @(posedge clk) begin
      if (!stall) begin
         mon_clk <= ~mon_clk;
      end
   end
endmodule
`default_nettype wire

/* File: dv/rsm_monitor.sv */
`default_nettype none
// ==========================================================
// Port checker for the reset source block.
module rsm_monitor #(
   parameter AW = 17
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic rst_pin_n,
   input wire logic flash_write,
   input wire logic flash_data_read,
   input wire logic [AW-1:0] flash_addr,
   input wire logic [AW-1:0] lock_byte_addr,
   input wire logic sys_rst_n,
   input wire logic digital_monitor_enable,
   input wire logic battery_monitor_enable
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   wire wr_ctrl = sfr_wr && sfr_addr == 8'hFF && sys_rst_n;
   sequence pin_low_s;
      !rst_pin_n [*6];
   endsequence
   sequence hold_s;
      !sys_rst_n [*4];
   endsequence
   rd_idle_a: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
      else $error("read data not idle");
   rd_ctrl_a: assert property ($past(sfr_rd && sfr_addr == 8'hFF && sys_rst_n) |->
      sfr_rdata[7] == $past(digital_monitor_enable) && sfr_rdata[3] == $past(battery_monitor_enable))
      else $error("control read wrong");
   ctrl_wr_a: assert property (wr_ctrl |=> digital_monitor_enable == $past(sfr_wdata[7]) &&
      battery_monitor_enable == $past(sfr_wdata[3])) else $error("control write lost");
   en_keep_a: assert property (!sys_rst_n |=> $stable(digital_monitor_enable) &&
      $stable(battery_monitor_enable)) else $error("monitor enable changed by reset");
   pin_reset_a: assert property (pin_low_s |=> !sys_rst_n)
      else $error("pin low without reset");
   rst_hold_a: assert property ($fell(sys_rst_n) |-> hold_s)
      else $error("reset too short");
   ferr_wr_a: assert property (flash_write && !digital_monitor_enable && sys_rst_n |=>
      !sys_rst_n) else $error("flash write error missed");
   ferr_rd_a: assert property (flash_data_read && flash_addr > lock_byte_addr && sys_rst_n
      |=> !sys_rst_n) else $error("flash read error missed");
endmodule
bind rsm_reset_source rsm_monitor #(.AW(AW)) rsm_monitor_i (.clk, .nrst, .sfr_addr,
   .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .rst_pin_n, .flash_write, .flash_data_read,
   .flash_addr, .lock_byte_addr, .sys_rst_n, .digital_monitor_enable, .battery_monitor_enable);
`default_nettype wire

/* File: dv/testbench.sv */
`default_nettype none
// ==========================================================
// Self-checking bench for the reset source block.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, nrst, ce, sfr_wr, sfr_rd, mon_clk, rst_pin_n, pin_req, stall;
   logic digital_supply_above_reset, digital_supply_above_warning;
   logic battery_supply_above_reset, battery_supply_above_warning;
   logic comp_pos_below_neg, comp_wake_enable, low_power, flash_write, flash_erase;
   logic flash_data_read, flash_prog_read, flash_secure_block, flash_write_enable;
   logic sys_rst_n, digital_monitor_enable, battery_monitor_enable;
   logic digital_warning_irq, battery_warning_irq;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   logic [16:0] flash_addr, lock_byte_addr;
   int fails = 0;
   int num_checks = 0;
   rsm_reset_source #(.WDT_LIMIT(16'h0004)) rsm_reset_source_i (.clk, .nrst, .ce, .sfr_addr,
      .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .rst_pin_n, .mon_clk,
      .digital_supply_above_reset, .digital_supply_above_warning, .battery_supply_above_reset,
      .battery_supply_above_warning, .comp_pos_below_neg, .comp_wake_enable, .low_power,
      .flash_write, .flash_erase, .flash_data_read, .flash_prog_read, .flash_addr,
      .lock_byte_addr, .flash_secure_block, .flash_write_enable, .sys_rst_n,
      .digital_monitor_enable, .battery_monitor_enable, .digital_warning_irq,
      .battery_warning_irq);
   rsm_ext_model rsm_ext_model_i (.clk, .pin_req, .stall, .rst_pin_n, .mon_clk);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic finish_test();
      $display("Checks %0d, errors %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      {sfr_addr, sfr_rd} = {a, 1'b1};
      @(negedge clk);
      sfr_rd = 1'b0;
      chk("sfr_rdata", e, sfr_rdata);
   endtask
   task automatic wait_lvl(input logic v, input int n);
      int i;
      for (i = 0; i < n && sys_rst_n !== v; i++) @(negedge clk);
      if (i == n) begin
         fails++;
         $display("FAIL sys_rst_n wait timed out");
         finish_test();
      end
   endtask
   task automatic rst_seq(input logic [7:0] c, input int n);
      wait_lvl(1'b0, n);
      wait_lvl(1'b1, 40);
      repeat (2) @(negedge clk);
      rd(8'hD9, 8'h01);
      wr(8'hD9, 8'h00);
      rd(8'hEF, c);
   endtask
   task automatic quiet(input int n);
      logic ok;
      ok = 1'b1;
      repeat (n) begin
         @(negedge clk);
         if (sys_rst_n !== 1'b1) ok = 1'b0;
      end
      chk("sys_rst_n", 8'h01, {7'h00, ok});
   endtask
   task automatic stat(input logic [3:0] s, input logic [7:0] e);
      {digital_supply_above_reset, digital_supply_above_warning} = s[3:2];
      {battery_supply_above_reset, battery_supply_above_warning} = s[1:0];
      repeat (6) @(negedge clk);
      rd(8'hFF, e);
   endtask
   task automatic fpulse(input logic w);
      @(negedge clk);
      {flash_write, flash_data_read} = {w, !w};
      @(negedge clk);
      {flash_write, flash_data_read} = 2'b00;
   endtask
   task automatic t_wdt();
      int n;
      low_power = 1'b1;
      quiet(150);
      low_power = 1'b0;
      repeat (3) begin
         quiet(40);
         wr(8'hD9, 8'h03);
      end
      wait_lvl(1'b0, 300);
      wait_lvl(1'b1, 40);
      for (n = 0; n < 100 && sys_rst_n !== 1'b0; n++) @(negedge clk);
      chk("wdt_cycles", 8'h3C, n[7:0]);
      rst_seq(8'h08, 5);
   endtask
   task automatic t_regs();
      rd(8'hFF, 8'hE0);
      wr(8'hFF, 8'hFF);
      rd(8'hFF, 8'hFF);
      stat(4'b1001, 8'hDB);
      chk("warning_irq", 8'h02, {6'h00, digital_warning_irq, battery_warning_irq});
      stat(4'b0110, 8'hBD);
      chk("warning_irq", 8'h01, {6'h00, digital_warning_irq, battery_warning_irq});
      stat(4'b1111, 8'hFF);
      chk("warning_irq", 8'h00, {6'h00, digital_warning_irq, battery_warning_irq});
      wr(8'hFF, 8'h00);
      rd(8'hFF, 8'h60);
      rd(8'h00, 8'h00);
   endtask
   task automatic t_ferr();
      fpulse(1'b1);
      rst_seq(8'h40, 10);
      chk("digital_monitor_enable", 8'h00, {7'h00, digital_monitor_enable});
      wr(8'hFF, 8'h80);
      flash_write_enable = 1'b1;
      flash_addr = lock_byte_addr;
      fpulse(1'b1);
      fpulse(1'b0);
      quiet(10);
      flash_addr = lock_byte_addr + 17'h00001;
      fpulse(1'b0);
      rst_seq(8'h40, 10);
      fpulse(1'b1);
      rst_seq(8'h40, 10);
      flash_addr = lock_byte_addr;
      flash_secure_block = 1'b1;
      fpulse(1'b0);
      rst_seq(8'h40, 10);
      flash_secure_block = 1'b0;
   endtask
   task automatic t_pin();
      {low_power, pin_req} = 2'b11;
      repeat (20) @(negedge clk);
      chk("sys_rst_n", 8'h00, {7'h00, sys_rst_n});
      pin_req = 1'b0;
      rst_seq(8'h01, 10);
      low_power = 1'b0;
   endtask
   task automatic t_comp();
      comp_pos_below_neg = 1'b0;
      wr(8'hEF, 8'h20);
      {low_power, comp_pos_below_neg} = 2'b11;
      quiet(10);
      comp_wake_enable = 1'b1;
      rst_seq(8'h20, 20);
      {low_power, comp_wake_enable} = 2'b00;
      wr(8'hEF, 8'h20);
      rst_seq(8'h20, 20);
      comp_pos_below_neg = 1'b0;
   endtask
   task automatic t_mcd();
      wr(8'hEF, 8'h04);
      {stall, low_power} = 2'b11;
      quiet(3000);
      low_power = 1'b0;
      rst_seq(8'h04, 2700);
      stall = 1'b0;
   endtask
   initial begin
      {nrst, ce, sfr_wr, sfr_rd, pin_req, stall, sfr_addr, sfr_wdata} = {6'b010000, 16'h0000};
      {digital_supply_above_reset, digital_supply_above_warning} = 2'b11;
      {battery_supply_above_reset, battery_supply_above_warning} = 2'b11;
      {comp_pos_below_neg, comp_wake_enable, low_power, flash_write, flash_erase} = 5'h00;
      {flash_data_read, flash_prog_read, flash_secure_block, flash_write_enable} = 4'h0;
      {flash_addr, lock_byte_addr} = {17'h00000, 17'h01000};
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      repeat (2) @(negedge clk);
      t_wdt();
      t_regs();
      t_ferr();
      t_pin();
      t_comp();
      t_mcd();
      finish_test();
   end
endmodule
`default_nettype wire

/* File: logic/rsm_regs.vh */
`ifndef RSM_REGS_VH
`define RSM_REGS_VH

// ==========================================================
// Register addresses on the special-function-register bus.
`define RSM_ADDR_SUPPLY_CTRL 8'hFF
`define RSM_ADDR_CAUSE 8'hEF
`define RSM_ADDR_WDT_CTRL 8'hD9

// ==========================================================
// Supply monitor control register fields.
`define RSM_SMC_DIG_EN 7
`define RSM_SMC_DIG_RST 6
`define RSM_SMC_DIG_WARN 5
`define RSM_SMC_DIG_IE 4
`define RSM_SMC_BAT_EN 3
`define RSM_SMC_BAT_RST 2
`define RSM_SMC_BAT_WARN 1
`define RSM_SMC_BAT_IE 0
`define RSM_SMC_DIG_EN_RST 1'b1
`define RSM_SMC_BAT_EN_RST 1'b0
`define RSM_SMC_IE_RST 1'b0

// ==========================================================
// Reset cause register fields.
`define RSM_RC_FERR 6
`define RSM_RC_COMP 5
`define RSM_RC_WDT 3
`define RSM_RC_MCD 2
`define RSM_RC_PIN 0

// ==========================================================
// Watchdog control register fields.
`define RSM_WDC_EN 0
`define RSM_WDC_KICK 1

// ==========================================================
// Timing.
`define RSM_CLK_KHZ 25000
`define RSM_MCD_TIME_US 100
`define RSM_MCD_CYCLES ((`RSM_MCD_TIME_US * `RSM_CLK_KHZ) / 1000)
`define RSM_WDT_DIV 12
`define RSM_RST_HOLD 4

`endif

/* File: logic/rsm_reset_source.v */
// Behaviour
// - Bit 7 enables digital supply monitor, resets 1.
// - Bit 6 shows digital supply above reset.
// - Bit 5 shows digital supply above warning.
// - Bit 4 gates digital warning interrupt.
// - Bit 3 enables battery monitor, resets 0.
// - Bit 2 shows battery above reset, reads 0 while bit 3 clear.
// - Bit 1 shows battery above warning, reads 0 while bit 3 clear.
// - Bit 0 gates battery warning interrupt.
// - Low reset pin holds device in reset.
// - Pin reset works asleep, sets pin flag.
// - Stalled system clock over 100 us resets.
// - Detector bit writes enable, reads cause flag.
// - Detector suppressed in low power, then restored.
// - Internal causes never touch the reset pin.
// - Enabled comparator resets when positive below negative.
// - Comparator flag; asleep only with wake enable.
// - Any reset enables watchdog, clock divided 12.
// - Unserviced watchdog resets and sets its flag.
// - Watchdog suppressed in low power, then restored.
// - Illegal flash accesses cause a system reset.
// - Flash error sets read-only flash flag.
// - Watchdog flag is read-only cause bit 3.
`include "rsm_regs.vh"
`default_nettype none

// ==========================================================
// Input synchroniser: three stages, change accepted on agreement.
module rsm_sync #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   input wire clk,
   input wire nrst,
   input wire ce,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] s1;
   reg [W-1:0] s2;
   reg [W-1:0] s3;
   integer i;

   always @(posedge clk) begin
      if (!nrst) begin
         s1 <= INIT;
         s2 <= INIT;
         s3 <= INIT;
         q <= INIT;
      end else if (ce) begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
         for (i = 0; i < W; i = i + 1) begin
            if (s2[i] == s3[i]) begin
               q[i] <= s3[i];
            end
         end
      end
   end
endmodule

// ==========================================================
// Reset source and supply monitor block.
module rsm_reset_source #(
   parameter AW = 17,
   parameter WDT_W = 16,
   parameter [WDT_W-1:0] WDT_LIMIT = 16'hFFFF,
   parameter MCD_W = 12
) (
   input wire clk,
   input wire nrst,
   input wire ce,
   input wire [7:0] sfr_addr,
   input wire [7:0] sfr_wdata,
   input wire sfr_wr,
   input wire sfr_rd,
   output reg [7:0] sfr_rdata,
   input wire rst_pin_n,
   input wire mon_clk,
   input wire digital_supply_above_reset,
   input wire digital_supply_above_warning,
   input wire battery_supply_above_reset,
   input wire battery_supply_above_warning,
   input wire comp_pos_below_neg,
   input wire comp_wake_enable,
   input wire low_power,
   input wire flash_write,
   input wire flash_erase,
   input wire flash_data_read,
   input wire flash_prog_read,
   input wire [AW-1:0] flash_addr,
   input wire [AW-1:0] lock_byte_addr,
   input wire flash_secure_block,
   input wire flash_write_enable,
   output reg sys_rst_n,
   output reg digital_monitor_enable,
   output reg battery_monitor_enable,
   output reg digital_warning_irq,
   output reg battery_warning_irq
);
   localparam ST_RUN = 1'b0;
   localparam ST_HOLD = 1'b1;
   localparam integer MCD_CYCLES = `RSM_MCD_CYCLES;
   localparam integer WDT_DIV_M1 = `RSM_WDT_DIV - 1;
   localparam integer HOLD_M1 = `RSM_RST_HOLD - 1;
   localparam [MCD_W-1:0] MCD_LIMIT = MCD_CYCLES[MCD_W-1:0];
   localparam [3:0] WDT_DIV_LAST = WDT_DIV_M1[3:0];
   localparam [2:0] HOLD_LAST = HOLD_M1[2:0];

   // =======================================================
   // Synchronised pin-side levels.
   wire [6:0] sync_q;
   wire pin_low = ~sync_q[0];
   wire mon_lvl = sync_q[1];
   wire dig_rst_ok = sync_q[2];
   wire dig_warn_ok = sync_q[3];
   wire bat_rst_ok = sync_q[4];
   wire bat_warn_ok = sync_q[5];
   wire comp_low = sync_q[6];

   rsm_sync #(.W(7), .INIT(7'h01)) u_sync (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .d({comp_pos_below_neg, battery_supply_above_warning, battery_supply_above_reset,
         digital_supply_above_warning, digital_supply_above_reset, mon_clk, rst_pin_n}),
      .q(sync_q)
   );

   // =======================================================
   // State.
   reg state;
   reg [2:0] hold_cnt;
   reg dig_ie;
   reg bat_ie;
   reg mcd_en;
   reg comp_en;
   reg wdt_en;
   reg [4:0] cause;
   reg mon_prev;
   reg [MCD_W-1:0] mcd_cnt;
   reg [3:0] wdt_pre;
   reg [WDT_W-1:0] wdt_cnt;

   wire wr_smc = sfr_wr && (sfr_addr == `RSM_ADDR_SUPPLY_CTRL);
   wire wr_cause = sfr_wr && (sfr_addr == `RSM_ADDR_CAUSE);
   wire wr_wdc = sfr_wr && (sfr_addr == `RSM_ADDR_WDT_CTRL);

   // =======================================================
   // Reset sources.
   // detector off in low power
   wire mcd_active = mcd_en && !low_power;
   wire mcd_fire = mcd_active && (mcd_cnt == MCD_LIMIT);
   wire comp_fire = comp_en && comp_low && (!low_power || comp_wake_enable);
   wire wdt_active = wdt_en && !low_power;
   wire wdt_tick = (wdt_pre == WDT_DIV_LAST);
   wire wdt_fire = wdt_active && wdt_tick && (wdt_cnt == WDT_LIMIT);
   wire above_lock = flash_addr > lock_byte_addr;
   wire fl_wr = flash_write || flash_erase;
   wire fl_any = fl_wr || flash_data_read || flash_prog_read;
   wire ferr_fire = (fl_wr && flash_write_enable && above_lock)
      || ((flash_data_read || flash_prog_read) && above_lock)
      || (fl_any && flash_secure_block)
      || (fl_wr && !digital_monitor_enable);
   wire any_src = pin_low || mcd_fire || comp_fire || wdt_fire || ferr_fire;

   reg [4:0] next_cause;
   always @* begin
      next_cause = 5'h00;
      if (pin_low) begin
         next_cause = 5'h01;
      end else if (mcd_fire) begin
         next_cause = 5'h02;
      end else if (comp_fire) begin
         next_cause = 5'h04;
      end else if (wdt_fire) begin
         next_cause = 5'h08;
      end else if (ferr_fire) begin
         next_cause = 5'h10;
      end
   end

   // =======================================================
   // Reset sequencer and control bits.
   always @(posedge clk) begin
      if (!nrst) begin
         state <= ST_RUN;
         hold_cnt <= 3'h0;
         sys_rst_n <= 1'b0;
         cause <= 5'h00;
         digital_monitor_enable <= `RSM_SMC_DIG_EN_RST;
         battery_monitor_enable <= `RSM_SMC_BAT_EN_RST;
         dig_ie <= `RSM_SMC_IE_RST;
         bat_ie <= `RSM_SMC_IE_RST;
         mcd_en <= 1'b0;
         comp_en <= 1'b0;
         wdt_en <= 1'b1;
      end else if (ce) begin
         case (state)
            ST_RUN: begin
               sys_rst_n <= 1'b1;
               // no pin drive from internal causes
               if (any_src) begin
                  state <= ST_HOLD;
                  sys_rst_n <= 1'b0;
                  hold_cnt <= 3'h0;
                  cause <= next_cause;
               end else begin
                  if (wr_smc) begin
                     digital_monitor_enable <= sfr_wdata[`RSM_SMC_DIG_EN];
                     dig_ie <= sfr_wdata[`RSM_SMC_DIG_IE];
                     battery_monitor_enable <= sfr_wdata[`RSM_SMC_BAT_EN];
                     bat_ie <= sfr_wdata[`RSM_SMC_BAT_IE];
                  end
                  if (wr_cause) begin
                     mcd_en <= sfr_wdata[`RSM_RC_MCD];
                     comp_en <= sfr_wdata[`RSM_RC_COMP];
                  end
                  if (wr_wdc) begin
                     wdt_en <= sfr_wdata[`RSM_WDC_EN];
                  end
               end
            end
            ST_HOLD: begin
               sys_rst_n <= 1'b0;
               dig_ie <= `RSM_SMC_IE_RST;
               bat_ie <= `RSM_SMC_IE_RST;
               mcd_en <= 1'b0;
               comp_en <= 1'b0;
               wdt_en <= 1'b1;
               if (pin_low) begin
                  hold_cnt <= 3'h0;
               end else if (hold_cnt == HOLD_LAST) begin
                  state <= ST_RUN;
                  sys_rst_n <= 1'b1;
               end else begin
                  hold_cnt <= hold_cnt + 3'h1;
               end
            end
            default: begin
               state <= ST_RUN;
            end
         endcase
      end
   end

   // =======================================================
   // Missing clock detector and watchdog counters.
   always @(posedge clk) begin
      if (!nrst) begin
         mon_prev <= 1'b0;
         mcd_cnt <= {MCD_W{1'b0}};
         wdt_pre <= 4'h0;
         wdt_cnt <= {WDT_W{1'b0}};
      end else if (ce) begin
         mon_prev <= mon_lvl;
         // count cycles without a level change
         if (!mcd_active || (mon_lvl != mon_prev) || state == ST_HOLD) begin
            mcd_cnt <= {MCD_W{1'b0}};
         end else if (mcd_cnt != MCD_LIMIT) begin
            mcd_cnt <= mcd_cnt + {{(MCD_W-1){1'b0}}, 1'b1};
         end
         if (state == ST_HOLD || wdt_tick) begin
            wdt_pre <= 4'h0;
         end else begin
            wdt_pre <= wdt_pre + 4'h1;
         end
         if (state == ST_HOLD || (wr_wdc && sfr_wdata[`RSM_WDC_KICK])) begin
            wdt_cnt <= {WDT_W{1'b0}};
         end else if (wdt_active && wdt_tick && wdt_cnt != WDT_LIMIT) begin
            wdt_cnt <= wdt_cnt + {{(WDT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // =======================================================
   // Read data and warning interrupt requests.
   // battery status masked
   wire bat_rst_vis = battery_monitor_enable && bat_rst_ok;
   wire bat_warn_vis = battery_monitor_enable && bat_warn_ok;

   always @(posedge clk) begin
      if (!nrst) begin
         sfr_rdata <= 8'h00;
         digital_warning_irq <= 1'b0;
         battery_warning_irq <= 1'b0;
      end else if (ce) begin
         digital_warning_irq <= dig_ie && digital_monitor_enable && !dig_warn_ok;
         battery_warning_irq <= bat_ie && battery_monitor_enable && !bat_warn_ok;
         sfr_rdata <= 8'h00;
         if (sfr_rd) begin
            case (sfr_addr)
               `RSM_ADDR_SUPPLY_CTRL: begin
                  sfr_rdata <= {digital_monitor_enable, dig_rst_ok, dig_warn_ok, dig_ie,
                     battery_monitor_enable, bat_rst_vis, bat_warn_vis, bat_ie};
               end
               `RSM_ADDR_CAUSE: begin
                  sfr_rdata <= {1'b0, cause[4], cause[2], 1'b0, cause[3], cause[1], 1'b0,
                     cause[0]};
               end
               `RSM_ADDR_WDT_CTRL: begin
                  sfr_rdata <= {7'h00, wdt_en};
               end
               default: begin
                  sfr_rdata <= 8'h00;
               end
            endcase
         end
      end
   end
endmodule

`default_nettype wire
